/* bench/lmb_ecc_model.sv */
// behavioural local memory controllers flagging uncorrectable errors
`timescale 1ns/1ps
module lmb_ecc_model #(
  parameter ECC_ON = 1
) (
  input  logic       i_core_clk,
  input  logic       i_arst_n,
  input  logic [1:0] i_inject,
  input  logic [1:0] i_flip,
  input  logic       i_scrub,
  input  logic [3:0] i_delay,
  output logic       o_ilmb_ue,
  output logic       o_dlmb_ue
);
  logic [1:0] pend_reg;
  logic [3:0] wait_reg;
  logic [1:0] sbe_reg;
  logic       scrub_rd_reg;
  logic [1:0] ue;
  // a second single-bit flip on an unscrubbed word is uncorrectable
  assign ue = i_inject | (i_flip & sbe_reg);
  // one ecc enable shared by both controllers
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_reg <= 2'h0;
      wait_reg <= 4'h0;
      sbe_reg <= 2'h0;
      scrub_rd_reg <= 1'b0;
      {o_ilmb_ue, o_dlmb_ue} <= 2'h0;
    end else begin
      {o_ilmb_ue, o_dlmb_ue} <= 2'h0;
      scrub_rd_reg <= i_scrub;
      // scrub read, then write-back of the corrected word
      if (scrub_rd_reg) begin
        sbe_reg <= 2'h0;
      end else begin
        sbe_reg <= sbe_reg | i_flip;
      end
      if (ue != 2'h0) begin
        pend_reg <= ECC_ON ? ue : 2'h0;
        wait_reg <= i_delay;
      end else if (wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end else begin
        {o_ilmb_ue, o_dlmb_ue} <= pend_reg;
        pend_reg <= 2'h0;
      end
    end
  end
endmodule

/* bench/ram_parity_properties.sv */
// port assertions for the ram parity protection block
`timescale 1ns/1ps
module ram_parity_checker (
  input logic          i_core_clk,
  input logic          i_arst_n,
  input logic          i_psel,
  input logic          i_penable,
  input logic          o_pready,
  input logic          i_ic_wr,
  input logic [19:0]   i_ic_wr_tag,
  input logic          o_ic_wr_tag_par,
  input logic [19:0]   i_dc_wr_tag,
  input logic          o_dc_wr_tag_par,
  input logic [31:0]   i_ic_wr_data,
  input logic          o_ic_wr_data_par,
  input logic          i_dc_wr,
  input logic [127:0]  i_dc_wr_data,
  input logic [15:0]   o_dc_wr_data_par,
  input logic          i_ic_hit,
  input logic [31:0]   i_ic_rd_data,
  input logic          i_ic_rd_data_par,
  input logic          o_ic_invalidate,
  input logic          i_btc_wr,
  input logic [31:0]   i_btc_wr_addr,
  input logic          o_btc_wr_par,
  input logic          i_btc_lookup,
  input logic [31:0]   i_btc_rd_addr,
  input logic          i_btc_rd_par,
  input logic          o_btc_take,
  input logic          o_dc_write_back,
  input logic          o_halt_error_output,
  input logic          o_ibus_exc,
  input logic          o_dbus_exc
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  function automatic logic [15:0] bytepar(input logic [127:0] d);
    for (int k = 0; k < 16; k++) bytepar[k] = ^d[8*k +: 8];
  endfunction
  property p_apb_wait; i_psel && i_penable && !o_pready |=> o_pready; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("no ready after access phase");
  property p_ic_word_par; i_ic_wr |=> o_ic_wr_data_par == ^$past(i_ic_wr_data); endproperty
  a_ic_word_par: assert property (p_ic_word_par) else $error("icache word parity wrong");
  property p_ic_tag_par; i_ic_wr |=> o_ic_wr_tag_par == ^$past(i_ic_wr_tag); endproperty
  a_ic_tag_par: assert property (p_ic_tag_par) else $error("icache tag parity wrong");
  property p_dc_tag_par; i_dc_wr |=> o_dc_wr_tag_par == ^$past(i_dc_wr_tag); endproperty
  a_dc_tag_par: assert property (p_dc_tag_par) else $error("dcache tag parity wrong");
  property p_dc_byte_par; i_dc_wr |=> o_dc_wr_data_par == bytepar($past(i_dc_wr_data)); endproperty
  a_dc_byte_par: assert property (p_dc_byte_par) else $error("dcache byte parity wrong");
  property p_ic_bad_hit; i_ic_hit && ^{i_ic_rd_data, i_ic_rd_data_par} |=> o_ic_invalidate; endproperty
  a_ic_bad_hit: assert property (p_ic_bad_hit) else $error("bad icache hit kept line");
  property p_btc_par; i_btc_wr |=> o_btc_wr_par == ^$past(i_btc_wr_addr); endproperty
  a_btc_par: assert property (p_btc_par) else $error("target parity wrong");
  property p_btc_drop; i_btc_lookup && ^{i_btc_rd_addr, i_btc_rd_par} |=> !o_btc_take; endproperty
  a_btc_drop: assert property (p_btc_drop) else $error("bad target was taken");
  property p_wt_only; !o_dc_write_back; endproperty
  a_wt_only: assert property (p_wt_only) else $error("write-back offered");
  property p_halt_final; o_halt_error_output |=> o_halt_error_output && !o_ibus_exc && !o_dbus_exc; endproperty
  a_halt_final: assert property (p_halt_final) else $error("halt left or exception after halt");
endmodule
bind ram_parity_protect ram_parity_checker u_chk (.i_core_clk, .i_arst_n, .i_psel, .i_penable, .o_pready,
  .i_ic_wr, .i_ic_wr_data, .o_ic_wr_data_par, .i_dc_wr, .i_dc_wr_data, .o_dc_wr_data_par, .i_ic_hit,
  .i_ic_rd_data, .i_ic_rd_data_par, .o_ic_invalidate, .i_btc_wr, .i_btc_wr_addr, .o_btc_wr_par, .i_btc_lookup,
  .i_btc_rd_addr, .i_btc_rd_par, .o_btc_take, .o_dc_write_back, .o_halt_error_output, .o_ibus_exc, .o_dbus_exc,
  .i_ic_wr_tag, .o_ic_wr_tag_par, .i_dc_wr_tag, .o_dc_wr_tag_par);

/* bench/tb.sv */
// self-checking bench for the ram parity protection block
`timescale 1ns/1ps
`include "ram_parity_consts.vh"
module tb;
  logic         i_core_clk = 0, i_arst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, i_exc_return = 0;
  logic         i_ic_wr = 0, i_ic_hit = 0, i_ic_rd_tag_par = 0, i_ic_rd_data_par = 0, i_dc_wr = 0, i_dc_hit = 0;
  logic         i_dc_rd_tag_par = 0, i_xlat_req = 0, i_btc_wr = 0, i_btc_lookup = 0, i_btc_rd_par = 0;
  logic [7:0]   i_paddr = 0;
  logic [5:0]   i_xlat_idx = 0;
  logic [19:0]  i_ic_wr_tag = 0, i_ic_rd_tag = 0, i_dc_wr_tag = 0, i_dc_rd_tag = 0;
  logic [31:0]  i_pwdata = 0, i_ic_wr_data = 0, i_ic_rd_data = 0, i_btc_wr_addr = 0, i_btc_rd_addr = 0;
  logic [127:0] i_dc_wr_data = 0, i_dc_rd_data = 0;
  logic [15:0]  i_dc_rd_data_par = 0, o_dc_wr_data_par;
  logic [31:0]  o_prdata, o_xlat_lo, o_btc_target;
  logic         o_pready, o_pslverr, o_ic_wr_tag_par, o_ic_wr_data_par, o_ic_invalidate, o_dc_wr_tag_par;
  logic         o_dc_invalidate, o_dc_write_back, o_xlat_miss, o_xlat_hit, o_btc_wr_par, o_btc_take;
  logic         o_ibus_exc, o_dbus_exc, o_halt_error_output, i_ilmb_ue, i_dlmb_ue;
  logic [1:0]   inj_req = 0, flip_req = 0;
  logic         scrub_req = 0;
  logic [3:0]   inj_dly = 0;
  logic [104:0] obs, q[$];
  int           errors = 0, check_count = 0;
  ram_parity_protect #(.FAULT_TOLERANT(1)) dut (
    .i_core_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_ic_wr, .i_ic_wr_tag, .i_ic_wr_data, .o_ic_wr_tag_par, .o_ic_wr_data_par, .i_ic_hit, .i_ic_rd_tag,
    .i_ic_rd_tag_par, .i_ic_rd_data, .i_ic_rd_data_par, .o_ic_invalidate, .i_dc_wr, .i_dc_wr_tag, .i_dc_wr_data,
    .o_dc_wr_tag_par, .o_dc_wr_data_par, .i_dc_hit, .i_dc_rd_tag, .i_dc_rd_tag_par, .i_dc_rd_data,
    .i_dc_rd_data_par, .o_dc_invalidate, .o_dc_write_back, .i_xlat_req, .i_xlat_idx, .o_xlat_miss, .o_xlat_hit,
    .o_xlat_lo, .i_btc_wr, .i_btc_wr_addr, .o_btc_wr_par, .i_btc_lookup, .i_btc_rd_addr, .i_btc_rd_par,
    .o_btc_take, .o_btc_target, .i_ilmb_ue, .i_dlmb_ue, .i_exc_return, .o_ibus_exc, .o_dbus_exc,
    .o_halt_error_output);
  lmb_ecc_model lmb (.i_core_clk, .i_arst_n, .i_inject(inj_req), .i_flip(flip_req), .i_scrub(scrub_req),
    .i_delay(inj_dly), .o_ilmb_ue(i_ilmb_ue), .o_dlmb_ue(i_dlmb_ue));
  initial forever #12.5 i_core_clk = ~i_core_clk;
  // event flags, then read data, taken target and translation low word
  assign obs = {o_pready, o_pslverr, o_ic_invalidate, o_dc_invalidate, o_btc_take, o_xlat_miss, o_xlat_hit,
    o_ibus_exc, o_dbus_exc, o_prdata & {32{o_pready & ~i_pwrite}}, o_btc_target & {32{o_btc_take}},
    o_xlat_lo & {32{o_xlat_hit}}};
  function automatic logic [15:0] bytepar(input logic [127:0] d);
    for (int k = 0; k < 16; k++) bytepar[k] = ^d[8*k +: 8];
  endfunction
  task chk(input logic [104:0] got, input logic [104:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    if (i_arst_n && |obs[104:96] === 1'b1) chk(obs, q.size() ? q.pop_front() : 105'h0);
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e, input logic er);
    int n;
    q.push_back({1'b1, er, 7'h0, w ? 32'h0 : e, 64'h0});
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk) i_penable <= 1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      end_of_test;
    end
    i_psel <= 0;
    i_penable <= 0;
    @(posedge i_core_clk);
  endtask
  task drain;
    for (int n = 0; n < 200 && q.size() != 0; n++) @(posedge i_core_clk);
    if (q.size() != 0) begin
      errors++;
      end_of_test;
    end
  endtask
  task xlat(input logic [104:0] e);
    q.push_back(e);
    i_xlat_req <= 1;
    i_xlat_idx <= 6'h05;
    @(posedge i_core_clk) i_xlat_req <= 0;
    drain;
  endtask
  task inj(input logic [1:0] m);
    inj_req <= m;
    inj_dly <= 4'($urandom_range(15, 0));
    @(posedge i_core_clk) inj_req <= 0;
  endtask
  task flip(input logic [1:0] m, input logic s);
    flip_req <= m;
    scrub_req <= s;
    inj_dly <= 4'($urandom_range(15, 0));
    @(posedge i_core_clk) flip_req <= 0;
    scrub_req <= 0;
    @(posedge i_core_clk);
  endtask
  task ret;
    i_exc_return <= 1;
    @(posedge i_core_clk) i_exc_return <= 0;
    @(posedge i_core_clk);
  endtask
  initial begin
    repeat (30000) @(posedge i_core_clk);
    errors++;
    end_of_test;
  end
  initial begin
    logic [31:0]  a, w, lo, hi;
    logic [127:0] d;
    logic [19:0]  t;
    logic         bad;
    void'($urandom(63997));
    repeat (20) @(posedge i_core_clk);
    i_arst_n <= 1;
    @(posedge i_core_clk);
    apb(0, `REG_STATUS, 0, 32'h4, 0);
    apb(0, 8'h20, 0, 0, 1);
    apb(1, 8'h24, 32'hffff_ffff, 0, 1);
    // back-to-back cache writes, hits and target lookups
    for (int k = 0; k < 8; k++) begin
      bad = k[0];
      a = $urandom;
      w = $urandom;
      t = 20'($urandom);
      d = {$urandom, $urandom, $urandom, $urandom};
      {i_ic_wr, i_dc_wr, i_btc_wr, i_ic_hit, i_dc_hit, i_btc_lookup} <= 6'h3f;
      {i_ic_wr_tag, i_ic_rd_tag, i_dc_wr_tag, i_dc_rd_tag} <= {4{t}};
      {i_ic_wr_data, i_ic_rd_data, i_btc_wr_addr, i_btc_rd_addr} <= {w, w, a, a};
      {i_dc_wr_data, i_dc_rd_data} <= {d, d};
      i_ic_rd_tag_par <= ^t ^ (bad & k[1]);
      i_dc_rd_tag_par <= ^t ^ (bad & k[1]);
      i_ic_rd_data_par <= ^w ^ (bad & !k[1]);
      i_dc_rd_data_par <= bytepar(d) ^ (16'(bad & !k[1]) << $urandom_range(15, 0));
      i_btc_rd_par <= ^a ^ bad;
      q.push_back(bad ? {9'h060, 96'h0} : {9'h010, 32'h0, a, 32'h0});
      @(posedge i_core_clk);
    end
    {i_ic_wr, i_dc_wr, i_btc_wr, i_ic_hit, i_dc_hit, i_btc_lookup} <= 6'h00;
    drain;
    apb(0, `REG_COUNT, 0, 32'h4, 0);
    lo = $urandom;
    hi = $urandom | 32'h40;
    apb(1, `REG_TLB_IDX, 5, 0, 0);
    apb(1, `REG_TLB_LO, lo, 0, 0);
    apb(1, `REG_TLB_HI, hi, 0, 0);
    apb(0, `REG_TLB_HI, 0, hi, 0);
    apb(0, `REG_TLB_LO, 0, lo, 0);
    xlat({9'h004, 64'h0, lo});
    apb(1, `REG_TLB_HI, hi & ~32'h40, 0, 0);
    xlat({9'h008, 96'h0});
    inj(2'b11);
    repeat (24) @(posedge i_core_clk);
    apb(1, `REG_CTRL, 32'h3, 0, 0);
    q.push_back({9'h002, 96'h0});
    inj(2'b11);
    drain;
    ret;
    q.push_back({9'h001, 96'h0});
    inj(2'b01);
    drain;
    ret;
    flip(2'b10, 0);
    flip(2'b00, 1);
    flip(2'b10, 0);
    q.push_back({9'h002, 96'h0});
    flip(2'b10, 0);
    drain;
    ret;
    q.push_back({9'h002, 96'h0});
    inj(2'b10);
    drain;
    q.push_back({9'h001, 96'h0});
    inj(2'b01);
    repeat (24) @(posedge i_core_clk);
    chk({104'h0, o_halt_error_output}, 105'h1);
    apb(0, `REG_STATUS, 0, 32'h7, 0);
    end_of_test;
  end
endmodule

/* common/ram_parity_consts.vh */
// constants for the processor ram parity protection block
//
// Contract
// - check cache parity on every cache hit
// - cache parity error invalidates the line
// - data cache is write-through only
// - store parity: tag, icache word, dcache byte
// - translation lookup parity error raises miss
// - translation write stores one parity bit
// - translation read error clears valid bit
// - target cache parity error drops prediction
// - target store computes one parity bit
// - enabled uncorrectable error raises bus exception
// - nested bus exception halts, asserts error
// - internal parity stays active without ecc
// - high write with valid clear invalidates
`ifndef RAM_PARITY_CONSTS_VH
`define RAM_PARITY_CONSTS_VH
`define TAG_W          20
`define IWORD_W        32
`define DLINE_W        128
`define DLINE_BYTES    16
`define BYTE_W         8
`define TLB_HI_W       32
`define TLB_LO_W       32
`define TLB_IDX_W      6
`define TLB_DEPTH      64
`define TLB_VALID_BIT  6
`define BTC_ADDR_W     32
`define APB_AW         8
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_TLB_IDX    8'h08
`define REG_TLB_HI     8'h0c
`define REG_TLB_LO     8'h10
`define REG_COUNT      8'h14
`define CTRL_EE_BIT    0
`define CTRL_WB_BIT    1
`define ST_HALT_BIT    0
`define ST_INEST_BIT   1
`define ST_WTONLY_BIT  2
`define ST_TLBPE_BIT   3
`define CNT_W          16
`define FT_STATE_RUN   2'h0
`define FT_STATE_EXC   2'h1
`define FT_STATE_HALT  2'h2
`endif

/* verilog/parity_unit.v */
// even parity generator and checker for one protected word
`timescale 1ns/1ps
module parity_unit #(
  parameter W = 8
) (
  input  wire [W-1:0] i_data,
  input  wire         i_par,
  output wire         o_par,
  output wire         o_err
);
  assign o_par = ^i_data;
  assign o_err = (^i_data) ^ i_par;
endmodule

/* verilog/ram_parity_protect.v */
// parity protection and bus error handling for the processor's internal rams
`timescale 1ns/1ps
`include "ram_parity_consts.vh"
module ram_parity_protect #(
  parameter FAULT_TOLERANT = 1
) (
  input  wire                     i_core_clk,
  input  wire                     i_arst_n,
  // apb register port
  input  wire                     i_psel,
  input  wire                     i_penable,
  input  wire                     i_pwrite,
  input  wire [`APB_AW-1:0]       i_paddr,
  input  wire [31:0]              i_pwdata,
  output reg  [31:0]              o_prdata,
  output reg                      o_pready,
  output reg                      o_pslverr,
  // instruction cache
  input  wire                     i_ic_wr,
  input  wire [`TAG_W-1:0]        i_ic_wr_tag,
  input  wire [`IWORD_W-1:0]      i_ic_wr_data,
  output reg                      o_ic_wr_tag_par,
  output reg                      o_ic_wr_data_par,
  input  wire                     i_ic_hit,
  input  wire [`TAG_W-1:0]        i_ic_rd_tag,
  input  wire                     i_ic_rd_tag_par,
  input  wire [`IWORD_W-1:0]      i_ic_rd_data,
  input  wire                     i_ic_rd_data_par,
  output reg                      o_ic_invalidate,
  // data cache
  input  wire                     i_dc_wr,
  input  wire [`TAG_W-1:0]        i_dc_wr_tag,
  input  wire [`DLINE_W-1:0]      i_dc_wr_data,
  output reg                      o_dc_wr_tag_par,
  output reg  [`DLINE_BYTES-1:0]  o_dc_wr_data_par,
  input  wire                     i_dc_hit,
  input  wire [`TAG_W-1:0]        i_dc_rd_tag,
  input  wire                     i_dc_rd_tag_par,
  input  wire [`DLINE_W-1:0]      i_dc_rd_data,
  input  wire [`DLINE_BYTES-1:0]  i_dc_rd_data_par,
  output reg                      o_dc_invalidate,
  output reg                      o_dc_write_back,
  // translation lookup
  input  wire                     i_xlat_req,
  input  wire [`TLB_IDX_W-1:0]    i_xlat_idx,
  output reg                      o_xlat_miss,
  output reg                      o_xlat_hit,
  output reg  [`TLB_LO_W-1:0]     o_xlat_lo,
  // branch target cache
  input  wire                     i_btc_wr,
  input  wire [`BTC_ADDR_W-1:0]   i_btc_wr_addr,
  output reg                      o_btc_wr_par,
  input  wire                     i_btc_lookup,
  input  wire [`BTC_ADDR_W-1:0]   i_btc_rd_addr,
  input  wire                     i_btc_rd_par,
  output reg                      o_btc_take,
  output reg  [`BTC_ADDR_W-1:0]   o_btc_target,
  // local memory bus uncorrectable errors
  input  wire                     i_ilmb_ue,
  input  wire                     i_dlmb_ue,
  input  wire                     i_exc_return,
  output reg                      o_ibus_exc,
  output reg                      o_dbus_exc,
  output reg                      o_halt_error_output
);
  localparam FT = (FAULT_TOLERANT != 0);

  // one parity bit per byte lane of a data cache line
  function [`DLINE_BYTES-1:0] line_par;
    input [`DLINE_W-1:0] d;
    integer k;
    begin
      line_par = {`DLINE_BYTES{1'b0}};
      for (k = 0; k < `DLINE_BYTES; k = k + 1) begin
        line_par[k] = ^d[k*`BYTE_W +: `BYTE_W];
      end
    end
  endfunction

  function addr_hit;
    input [`APB_AW-1:0] a;
    input [`APB_AW-1:0] r;
    begin
      addr_hit = (a == r);
    end
  endfunction

  // parity checkers
  wire ic_tag_err;
  wire ic_dat_err;
  wire dc_tag_err;
  wire btc_err;
  wire [`DLINE_BYTES-1:0] dc_rd_calc;
  wire dc_dat_err;

  parity_unit #(.W(`TAG_W)) u_ic_tag (
    .i_data (i_ic_rd_tag),
    .i_par  (i_ic_rd_tag_par),
    .o_par  (),
    .o_err  (ic_tag_err)
  );
  parity_unit #(.W(`IWORD_W)) u_ic_dat (
    .i_data (i_ic_rd_data),
    .i_par  (i_ic_rd_data_par),
    .o_par  (),
    .o_err  (ic_dat_err)
  );
  parity_unit #(.W(`TAG_W)) u_dc_tag (
    .i_data (i_dc_rd_tag),
    .i_par  (i_dc_rd_tag_par),
    .o_par  (),
    .o_err  (dc_tag_err)
  );
  parity_unit #(.W(`BTC_ADDR_W)) u_btc (
    .i_data (i_btc_rd_addr),
    .i_par  (i_btc_rd_par),
    .o_par  (),
    .o_err  (btc_err)
  );
  assign dc_rd_calc = line_par(i_dc_rd_data);
  assign dc_dat_err = |(dc_rd_calc ^ i_dc_rd_data_par);

  // translation buffer with one parity bit per entry
  reg [`TLB_HI_W-1:0] tlb_hi_mem [0:`TLB_DEPTH-1];
  reg [`TLB_LO_W-1:0] tlb_lo_mem [0:`TLB_DEPTH-1];
  reg                 tlb_par_mem [0:`TLB_DEPTH-1];

  reg                 ee_reg;
  reg                 wb_req_reg;
  reg [`TLB_IDX_W-1:0] tlb_idx_reg;
  reg [`TLB_LO_W-1:0] tlb_lo_reg;
  reg                 tlb_pe_reg;
  reg [`CNT_W-1:0]    err_cnt_reg;
  reg [1:0]           ft_state_reg;
  reg                 inest_reg;

  wire apb_acc = i_psel & i_penable;
  wire apb_wr  = apb_acc & i_pwrite;
  wire apb_rd  = apb_acc & ~i_pwrite;
  wire hit_ctrl = addr_hit(i_paddr, `REG_CTRL);
  wire hit_stat = addr_hit(i_paddr, `REG_STATUS);
  wire hit_idx  = addr_hit(i_paddr, `REG_TLB_IDX);
  wire hit_hi   = addr_hit(i_paddr, `REG_TLB_HI);
  wire hit_lo   = addr_hit(i_paddr, `REG_TLB_LO);
  wire hit_cnt  = addr_hit(i_paddr, `REG_COUNT);
  wire mapped   = hit_ctrl | hit_stat | hit_idx | hit_hi | hit_lo | hit_cnt;

  // stored entry parity covers both halves
  wire [`TLB_HI_W-1:0] sel_hi  = tlb_hi_mem[tlb_idx_reg];
  wire [`TLB_LO_W-1:0] sel_lo  = tlb_lo_mem[tlb_idx_reg];
  wire                 sel_err = FT & ((^{sel_hi, sel_lo}) ^ tlb_par_mem[tlb_idx_reg]);
  wire [`TLB_HI_W-1:0] xl_hi   = tlb_hi_mem[i_xlat_idx];
  wire [`TLB_LO_W-1:0] xl_lo   = tlb_lo_mem[i_xlat_idx];
  wire                 xl_err  = FT & ((^{xl_hi, xl_lo}) ^ tlb_par_mem[i_xlat_idx]);

  wire ic_err = FT & i_ic_hit & (ic_tag_err | ic_dat_err);
  wire dc_err = FT & i_dc_hit & (dc_tag_err | dc_dat_err);
  wire bt_err = FT & i_btc_lookup & btc_err;
  wire tlb_rd_err = apb_rd & hit_hi & sel_err;
  wire xl_pe = i_xlat_req & xl_err;
  wire bus_ue = FT & ee_reg & (i_ilmb_ue | i_dlmb_ue);

  integer n;

  // apb slave and translation buffer writes
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ee_reg      <= 1'b0;
      wb_req_reg  <= 1'b0;
      tlb_idx_reg <= {`TLB_IDX_W{1'b0}};
      tlb_lo_reg  <= {`TLB_LO_W{1'b0}};
      o_prdata    <= 32'h0;
      o_pready    <= 1'b0;
      o_pslverr   <= 1'b0;
      for (n = 0; n < `TLB_DEPTH; n = n + 1) begin
        tlb_hi_mem[n]  <= {`TLB_HI_W{1'b0}};
        tlb_lo_mem[n]  <= {`TLB_LO_W{1'b0}};
        tlb_par_mem[n] <= 1'b0;
      end
    end else begin
      o_pready  <= i_psel & i_penable & ~o_pready;
      o_pslverr <= i_psel & i_penable & ~o_pready & ~mapped;
      o_prdata  <= 32'h0;
      if (apb_wr & ~o_pready) begin
        if (hit_ctrl) begin
          ee_reg     <= i_pwdata[`CTRL_EE_BIT];
          wb_req_reg <= i_pwdata[`CTRL_WB_BIT];
        end
        if (hit_idx) begin
          tlb_idx_reg <= i_pwdata[`TLB_IDX_W-1:0];
        end
        if (hit_lo) begin
          tlb_lo_reg <= i_pwdata;
        end
        // writing the high half commits the entry
        if (hit_hi) begin
          tlb_hi_mem[tlb_idx_reg]  <= i_pwdata;
          tlb_lo_mem[tlb_idx_reg]  <= tlb_lo_reg;
          tlb_par_mem[tlb_idx_reg] <= FT & (^{i_pwdata, tlb_lo_reg});
        end
      end
      if (apb_rd & ~o_pready) begin
        if (hit_ctrl) begin
          o_prdata[`CTRL_EE_BIT] <= ee_reg;
          o_prdata[`CTRL_WB_BIT] <= wb_req_reg;
        end
        if (hit_stat) begin
          o_prdata[`ST_HALT_BIT]   <= (ft_state_reg == `FT_STATE_HALT);
          o_prdata[`ST_INEST_BIT]  <= inest_reg;
          o_prdata[`ST_WTONLY_BIT] <= FT;
          o_prdata[`ST_TLBPE_BIT]  <= tlb_pe_reg;
        end
        if (hit_idx) begin
          o_prdata[`TLB_IDX_W-1:0] <= tlb_idx_reg;
        end
        if (hit_hi) begin
          o_prdata <= sel_err ? (sel_hi & ~(32'h1 << `TLB_VALID_BIT)) : sel_hi;
          if (sel_err) begin
            tlb_hi_mem[tlb_idx_reg] <= sel_hi & ~(32'h1 << `TLB_VALID_BIT);
          end
        end
        if (hit_lo) begin
          o_prdata <= sel_lo;
        end
        if (hit_cnt) begin
          o_prdata[`CNT_W-1:0] <= err_cnt_reg;
        end
      end
    end
  end

  // exception nesting state
  reg [1:0] ft_state_next;
  always @* begin
    ft_state_next = ft_state_reg;
    case (ft_state_reg)
      `FT_STATE_RUN: begin
        if (bus_ue) begin
          ft_state_next = `FT_STATE_EXC;
        end
      end
      `FT_STATE_EXC: begin
        if (bus_ue) begin
          ft_state_next = `FT_STATE_HALT;
        end else if (i_exc_return) begin
          ft_state_next = `FT_STATE_RUN;
        end
      end
      `FT_STATE_HALT: begin
        ft_state_next = `FT_STATE_HALT;
      end
      default: begin
        ft_state_next = `FT_STATE_RUN;
      end
    endcase
  end

  // recovery outputs
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ft_state_reg        <= `FT_STATE_RUN;
      inest_reg           <= 1'b0;
      tlb_pe_reg          <= 1'b0;
      err_cnt_reg         <= {`CNT_W{1'b0}};
      o_ic_invalidate     <= 1'b0;
      o_dc_invalidate     <= 1'b0;
      o_dc_write_back     <= 1'b0;
      o_ic_wr_tag_par     <= 1'b0;
      o_ic_wr_data_par    <= 1'b0;
      o_dc_wr_tag_par     <= 1'b0;
      o_dc_wr_data_par    <= {`DLINE_BYTES{1'b0}};
      o_xlat_miss         <= 1'b0;
      o_xlat_hit          <= 1'b0;
      o_xlat_lo           <= {`TLB_LO_W{1'b0}};
      o_btc_wr_par        <= 1'b0;
      o_btc_take          <= 1'b0;
      o_btc_target        <= {`BTC_ADDR_W{1'b0}};
      o_ibus_exc          <= 1'b0;
      o_dbus_exc          <= 1'b0;
      o_halt_error_output <= 1'b0;
    end else begin
      ft_state_reg    <= ft_state_next;
      o_ic_invalidate <= ic_err;
      o_dc_invalidate <= dc_err;
      o_dc_write_back <= ~FT & wb_req_reg;
      if (i_ic_wr) begin
        o_ic_wr_tag_par  <= FT & (^i_ic_wr_tag);
        o_ic_wr_data_par <= FT & (^i_ic_wr_data);
      end
      if (i_dc_wr) begin
        o_dc_wr_tag_par  <= FT & (^i_dc_wr_tag);
        o_dc_wr_data_par <= FT ? line_par(i_dc_wr_data) : {`DLINE_BYTES{1'b0}};
      end
      o_xlat_miss <= xl_pe | (i_xlat_req & ~xl_hi[`TLB_VALID_BIT]);
      o_xlat_hit  <= i_xlat_req & ~xl_pe & xl_hi[`TLB_VALID_BIT];
      o_xlat_lo   <= xl_lo;
      if (i_btc_wr) begin
        o_btc_wr_par <= FT & (^i_btc_wr_addr);
      end
      o_btc_take   <= i_btc_lookup & ~bt_err;
      o_btc_target <= i_btc_rd_addr;
      o_ibus_exc   <= bus_ue & i_ilmb_ue & (ft_state_reg != `FT_STATE_HALT);
      o_dbus_exc   <= bus_ue & ~i_ilmb_ue & (ft_state_reg != `FT_STATE_HALT);
      if (ft_state_next == `FT_STATE_HALT) begin
        o_halt_error_output <= 1'b1;
        inest_reg           <= 1'b1;
      end
      // set wins over clear
      if (tlb_rd_err | xl_pe) begin
        tlb_pe_reg <= 1'b1;
      end else if (apb_wr & hit_stat & ~o_pready & i_pwdata[`ST_TLBPE_BIT]) begin
        tlb_pe_reg <= 1'b0;
      end
      if ((ic_err | dc_err | bt_err | xl_pe) & ~(&err_cnt_reg)) begin
        err_cnt_reg <= err_cnt_reg + {{(`CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
